/* File: src/adc_link_defines.svh */
/*
  named figures of the converter serial link: frame length, times as
  printed and the core clock cycle counts derived from them.
  assumes a single core clock of 250 MHz on both ends of the link.
*/
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

// frame and resolution
`define FRAME_BITS 16
`define RES_WIDE 14
`define RES_NARROW 12

// core clock period in ps
`define CLK_PERIOD_PS 4000
`define CYC_UP(t) (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DN(t) ((t) / `CLK_PERIOD_PS)

// strobe to clock setup, 3 ns
`define SETUP_TIME_PS 3000
`define SETUP_CYC `CYC_UP(`SETUP_TIME_PS)
// 16th clock rise to next strobe rise, 45 ns
`define ACQ_TIME_PS 45000
`define ACQ_CYC `CYC_UP(`ACQ_TIME_PS)
// least sampling period, 286 ns
`define THRU_TIME_PS 286000
`define THRU_CYC `CYC_UP(`THRU_TIME_PS)
// serial clock period bounds, 15.872 ns and 10000 ns
`define SCK_MIN_PS 15872
`define SCK_MAX_PS 10000000
`define SCK_HALF_MIN ((`SCK_MIN_PS + 2 * `CLK_PERIOD_PS - 1) / (2 * `CLK_PERIOD_PS))
`define SCK_HALF_MAX (`SCK_MAX_PS / (2 * `CLK_PERIOD_PS))
// reference settling after wake, 2 ms
`define WAKE_TIME_MS 2
`define WAKE_CYC (`WAKE_TIME_MS * (1000000000 / `CLK_PERIOD_PS))

// power-down pulse counts
`define NAP_PULSES 2
`define SLEEP_PULSES 4

// pin filter plus shifter plus pin filter, host clock rise to bit seen
`define LINK_LAT_CYC 9

`endif

/* File: src/adc_link_pkg.sv */
/*
  types shared by both ends of the converter serial link.
  assumes adc_link_defines.svh is on the include path.
*/
`include "adc_link_defines.svh"

package adc_link_pkg;

  // power state of the converter, one-hot
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h1,
    MODE_NAP = 3'h2,
    MODE_SLEEP = 3'h4
  } power_mode_type;

  // host sequencer phases, one-hot
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_CONVERT_START_STROBE = 7'h02,
    H_CLOCK = 7'h04,
    H_ACQ = 7'h08,
    H_PWR = 7'h10,
    H_WAKE = 7'h20,
    H_SETTLE = 7'h40
  } host_phase_type;

  typedef logic [19:0] cnt_type;
  typedef logic [`FRAME_BITS-1:0] word_type;

  // three-stage pin filter
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_type;

  // converter end
  typedef struct packed {
    power_mode_type mode;
    logic convert_start_strobe_lvl;
    logic sck_lvl;
    logic framing;
    logic skip;
    logic driving;
    logic acquiring;
    logic [2:0] setup_cnt;
    logic [4:0] bit_cnt;
    logic [2:0] pulses;
    word_type shift;
    word_type held;
    word_type result;
  } device_state_type;

  // host end
  typedef struct packed {
    host_phase_type phase;
    power_mode_type mode;
    logic convert_start_strobe;
    logic sck;
    logic valid;
    cnt_type cnt;
    logic [4:0] rises;
    logic [2:0] pulses;
    logic [2:0] target;
    logic [7:0] thru;
    word_type data;
    word_type out;
  } host_state_type;

endpackage : adc_link_pkg

/* File: src/adc_link_if.sv */
/*
  the three-wire link between converter and host.
  assumes both ends run on the same core clock; the data wire is
  resolved here from the converter's drive enable.
*/
interface adc_link_if;
  logic convert_start_strobe;
  logic sck;
  logic sdo_drv;
  logic sdo_oe;
  logic sdo_line;

  // released data wire reads low, as through a pull-down
  assign sdo_line = sdo_oe & sdo_drv;

  modport device (input convert_start_strobe, input sck, output sdo_drv, output sdo_oe);
  modport host (output convert_start_strobe, output sck, input sdo_line);
endinterface : adc_link_if

/* File: src/pin_sync_filter.sv */
/*
  four flip-flop filter for one pin input; the level changes once the
  second and third stages agree.
  assumes a pin from outside the core clock domain.
*/
module pin_sync_filter
  import adc_link_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic level_o
);

  sync_state_type r;
  sync_state_type next_r;

  // first stage feeds only the second
  always_comb begin
    next_r.s1 = pin_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.lvl = (r.s2 == r.s3) ? r.s3 : r.lvl;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_o = r.lvl;

endmodule : pin_sync_filter

/* File: src/adc_device_end.sv */
/*
  converter end of the serial link: input hold and difference, clamp to
  the result range, conversion sequencing on serial clock rises, the
  three-state result shifter and the pulse-count power-down modes.
  assumes strobe and serial clock arrive as pins from the host, and the
  two analog inputs as signed codes scaled to one result step per unit.
*/
// How it works
// - strobe rise holds input, starts conversion
// - conversion and shifting advance on clock rises
// - acquisition from 16th rise to strobe rise
// - host leaves 45 ns before next strobe
// - strobe too close to clock delays data
// - host raises strobe half clock early
// - shifted word is the previous conversion
// - results are two's complement
// - data line released after the last bit
// - host samples data on clock rises
// - two strobes, clock still: nap
// - four or more strobes, clock still: sleep
// - clock pulse wakes from sleep
// - host waits 2 ms after wake from sleep
// - at most one conversion per 286 ns
// - clock period bounded during conversion
// - result is 14 or 12 bits
// - out-of-range input clamps to end codes
`include "adc_link_defines.svh"

module adc_device_end
  import adc_link_pkg::*;
#(
  parameter int RES_BITS = `RES_WIDE,
  parameter int IN_W = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  adc_link_if.device link,
  input wire logic signed [IN_W-1:0] noninverting_analog_input_i,
  input wire logic signed [IN_W-1:0] inverting_analog_input_i,
  output logic [2:0] power_state_o,
  output logic acquiring_o
);

  // pads the result up to the frame, low bits zero
  localparam int PAD = `FRAME_BITS - RES_BITS;
  localparam int PIN_N = 2;
  localparam int PIN_SCK = 0;
  localparam int PIN_CONVERT_START_STROBE = 1;
  localparam logic [4:0] LAST_BIT = 5'(`FRAME_BITS - 1);
  localparam logic [2:0] SETUP_LD = 3'(`SETUP_CYC - 1);
  localparam logic [2:0] NAP_N = 3'(`NAP_PULSES);
  localparam logic [2:0] SLEEP_N = 3'(`SLEEP_PULSES);
  localparam device_state_type DEVICE_RESET = '{mode: MODE_ACTIVE, default: '0};

  // clamp a difference into the signed result range
  function automatic word_type saturate(input logic signed [IN_W:0] diff);
    int value;
    int top;
    int bottom;
    value = int'(diff);
    top = (1 <<< (RES_BITS - 1)) - 1;
    bottom = -top - 1;
    if (value > top) begin
      value = top;
    end else if (value < bottom) begin
      value = bottom;
    end
    return value[`FRAME_BITS-1:0];
  endfunction : saturate

  // rising edge of a filtered pin level
  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction : rose

  // converter awake, decoded in several places
  function automatic logic is_active(input power_mode_type m);
    return m == MODE_ACTIVE;
  endfunction : is_active

  // state, filtered pins and decoded edges
  device_state_type r;
  device_state_type next_r;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic convert_start_strobe_rise;
  logic sck_rise;
  logic sck_edge;
  logic start;
  logic [2:0] next_pulses;
  logic signed [IN_W:0] diff;

  // both link inputs are pins and go through the filter
  assign pin_raw[PIN_SCK] = link.sck;
  assign pin_raw[PIN_CONVERT_START_STROBE] = link.convert_start_strobe;

  // one three-stage filter per pin
  generate
    for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      pin_sync_filter u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i(pin_raw[i]),
        .level_o(pin_lvl[i])
      );
    end
  endgenerate

  // edge detection and analog difference
  always_comb begin
    convert_start_strobe_rise = rose(pin_lvl[PIN_CONVERT_START_STROBE], r.convert_start_strobe_lvl);
    sck_rise = rose(pin_lvl[PIN_SCK], r.sck_lvl);
    sck_edge = pin_lvl[PIN_SCK] != r.sck_lvl;
    diff = (IN_W + 1)'(noninverting_analog_input_i)
        - (IN_W + 1)'(inverting_analog_input_i);
  end

  // next state of the whole converter
  always_comb begin
    next_r = r;
    next_r.convert_start_strobe_lvl = pin_lvl[PIN_CONVERT_START_STROBE];
    next_r.sck_lvl = pin_lvl[PIN_SCK];

    // strobe pulses counted while the clock stands still
    next_pulses = r.pulses;
    if (sck_edge) begin
      next_pulses = '0;
    end else if (convert_start_strobe_rise && r.pulses != SLEEP_N) begin
      next_pulses = r.pulses + 3'h1;
    end
    next_r.pulses = next_pulses;

    // power mode: a clock rise wakes, strobe counts put it down
    if (sck_rise) begin
      next_r.mode = MODE_ACTIVE;
    end else if (convert_start_strobe_rise && next_pulses == SLEEP_N) begin
      next_r.mode = MODE_SLEEP;
    end else if (convert_start_strobe_rise && next_pulses == NAP_N && is_active(r.mode)) begin
      next_r.mode = MODE_NAP;
    end

    // a strobe rise starts a conversion only when awake
    start = convert_start_strobe_rise && is_active(r.mode) && is_active(next_r.mode);

    // setup window after a strobe rise
    if (r.setup_cnt != '0) begin
      next_r.setup_cnt = r.setup_cnt - 3'h1;
    end

    // any strobe rise closes the acquisition interval
    if (convert_start_strobe_rise) begin
      next_r.acquiring = 1'b0;
    end

    // frame control: start, power-down, then clock rises
    if (start) begin
      // hold the new sample, clamped, and present the previous result
      next_r.held = saturate(diff);
      next_r.shift = r.result << PAD;
      next_r.framing = 1'b1;
      next_r.bit_cnt = '0;
      // a clock rise with the strobe costs one clock of latency
      next_r.skip = sck_rise;
      next_r.driving = ~sck_rise;
      next_r.setup_cnt = SETUP_LD;
    end else if (!is_active(next_r.mode)) begin
      // powering down abandons the frame and frees the line
      next_r.framing = 1'b0;
      next_r.driving = 1'b0;
      next_r.skip = 1'b0;
    end else if (sck_rise && r.framing) begin
      if (r.skip || r.setup_cnt != '0) begin
        // late start: this rise only brings the first bit up
        next_r.skip = 1'b0;
        next_r.driving = 1'b1;
        next_r.setup_cnt = '0;
      end else begin
        // one bit and one conversion step per clock rise
        next_r.shift = r.shift << 1;
        next_r.bit_cnt = r.bit_cnt + 5'h01;
        if (r.bit_cnt == LAST_BIT) begin
          // 16th rise ends the word and the conversion
          next_r.framing = 1'b0;
          next_r.driving = 1'b0;
          next_r.result = r.held;
          next_r.acquiring = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      r <= DEVICE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs all come from the state register
  assign link.sdo_drv = r.shift[`FRAME_BITS-1];
  assign link.sdo_oe = r.driving;
  assign power_state_o = r.mode;
  assign acquiring_o = r.acquiring;

endmodule : adc_device_end

/* File: src/adc_host_end.sv */
/*
  host end of the converter serial link: makes the serial clock by a
  divider, pulses the strobe, reads the result word and sends the
  power-down and wake sequences.
  assumes the converter end on the same core clock; the data wire is a
  pin and goes through the three-stage filter.
*/
`include "adc_link_defines.svh"

module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int RES_BITS = `RES_WIDE,
  parameter int SCK_HALF = 10,
  parameter int WAKE_CYC = `WAKE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  adc_link_if.host link,
  input wire logic start_i,
  input wire logic nap_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  output logic ready_o,
  output logic [RES_BITS-1:0] data_o,
  output logic data_valid_o,
  output logic [2:0] power_state_o
);

  // half period held inside the clock bounds and above the link latency
  localparam int HALF_A = (SCK_HALF > `SCK_HALF_MIN) ? SCK_HALF : `SCK_HALF_MIN;
  localparam int HALF_B = (HALF_A > `LINK_LAT_CYC) ? HALF_A : `LINK_LAT_CYC + 1;
  localparam int HALF = (HALF_B < `SCK_HALF_MAX) ? HALF_B : `SCK_HALF_MAX;
  localparam cnt_type HALF_LD = cnt_type'(HALF - 1);
  localparam cnt_type ACQ_LD = cnt_type'(`ACQ_CYC - 1);
  localparam cnt_type WAKE_LD = cnt_type'(WAKE_CYC - 1);
  localparam logic [7:0] THRU_N = 8'(`THRU_CYC);
  localparam logic [4:0] RISES_N = 5'(`FRAME_BITS);
  localparam logic [2:0] NAP_N = 3'(`NAP_PULSES);
  localparam logic [2:0] SLEEP_N = 3'(`SLEEP_PULSES);
  localparam host_state_type HOST_RESET = '{phase: H_IDLE, mode: MODE_ACTIVE, default: '0};

  host_state_type r;
  host_state_type next_r;
  logic sdo_lvl;

  pin_sync_filter u_sdo_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(link.sdo_line),
    .level_o(sdo_lvl)
  );

  // sequencer
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (r.phase != H_IDLE && r.thru != THRU_N) begin
      next_r.thru = r.thru + 8'h01;
    end
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - cnt_type'(1);
    end
    unique case (r.phase)
      H_IDLE: begin
        if (start_i && r.mode == MODE_ACTIVE) begin
          // strobe rises half a clock before the first rise
          next_r.convert_start_strobe = 1'b1;
          next_r.thru = '0;
          next_r.cnt = HALF_LD;
          next_r.phase = H_CONVERT_START_STROBE;
        end else if ((sleep_i || nap_i) && r.mode == MODE_ACTIVE) begin
          next_r.target = sleep_i ? SLEEP_N : NAP_N;
          next_r.pulses = '0;
          next_r.convert_start_strobe = 1'b1;
          next_r.cnt = HALF_LD;
          next_r.phase = H_PWR;
        end else if (wake_i && r.mode != MODE_ACTIVE) begin
          next_r.sck = 1'b1;
          next_r.cnt = HALF_LD;
          next_r.phase = H_WAKE;
        end
      end
      H_CONVERT_START_STROBE: begin
        if (r.cnt == '0) begin
          // first rise: take the first bit, drop the strobe
          next_r.sck = 1'b1;
          next_r.convert_start_strobe = 1'b0;
          next_r.data = {r.data[`FRAME_BITS-2:0], sdo_lvl};
          next_r.rises = 5'h01;
          next_r.cnt = HALF_LD;
          next_r.phase = H_CLOCK;
        end
      end
      H_CLOCK: begin
        if (r.cnt == '0) begin
          next_r.cnt = HALF_LD;
          if (r.sck) begin
            next_r.sck = 1'b0;
            if (r.rises == RISES_N) begin
              next_r.out = r.data;
              next_r.valid = 1'b1;
              next_r.cnt = ACQ_LD;
              next_r.phase = H_ACQ;
            end
          end else begin
            next_r.sck = 1'b1;
            next_r.data = {r.data[`FRAME_BITS-2:0], sdo_lvl};
            next_r.rises = r.rises + 5'h01;
          end
        end
      end
      H_ACQ: begin
        // acquisition time and sampling period both met
        if (r.cnt == '0 && r.thru == THRU_N) begin
          next_r.phase = H_IDLE;
        end
      end
      H_PWR: begin
        // strobe pulses with the clock held low
        if (r.cnt == '0) begin
          next_r.cnt = HALF_LD;
          if (r.convert_start_strobe) begin
            next_r.convert_start_strobe = 1'b0;
            next_r.pulses = r.pulses + 3'h1;
            if (r.pulses + 3'h1 == r.target) begin
              next_r.mode = (r.target == SLEEP_N) ? MODE_SLEEP : MODE_NAP;
              next_r.phase = H_IDLE;
            end
          end else begin
            next_r.convert_start_strobe = 1'b1;
          end
        end
      end
      H_WAKE: begin
        if (r.cnt == '0) begin
          next_r.sck = 1'b0;
          next_r.mode = MODE_ACTIVE;
          next_r.cnt = WAKE_LD;
          next_r.phase = (r.mode == MODE_SLEEP) ? H_SETTLE : H_IDLE;
        end
      end
      H_SETTLE: begin
        // reference settles before the next conversion
        if (r.cnt == '0) begin
          next_r.phase = H_IDLE;
        end
      end
      default: begin
        next_r = HOST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      r <= HOST_RESET;
    end else begin
      r <= next_r;
    end
  end

  // link pins and user outputs
  assign link.convert_start_strobe = r.convert_start_strobe;
  assign link.sck = r.sck;
  assign ready_o = r.phase == H_IDLE;
  assign data_o = r.out[`FRAME_BITS-1 -: RES_BITS];
  assign data_valid_o = r.valid;
  assign power_state_o = r.mode;

endmodule : adc_host_end

/* File: test/adc_link_asserts.sv */
/*
  link checker: data wire timing against strobe and serial clock rises.
  assumes one core clock and a sync active-low reset for both ends.
*/
module adc_link_asserts #(
  parameter int RES_BITS = 14
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic convert_start_strobe,
  input wire logic sck,
  input wire logic sdo_drv,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic convert_start_strobe_q;
  logic sck_q;
  logic [4:0] rises;
  logic [4:0] convert_start_strobe_age;
  logic [4:0] sck_age;
  logic [4:0] quiet;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // edge history, rises since strobe, saturating ages
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      convert_start_strobe_q <= 1'h0;
      sck_q <= 1'h0;
      rises <= 5'h00;
      convert_start_strobe_age <= 5'h1f;
      sck_age <= 5'h1f;
      quiet <= 5'h00;
    end else begin
      convert_start_strobe_q <= convert_start_strobe;
      sck_q <= sck;
      rises <= (convert_start_strobe && !convert_start_strobe_q) ? 5'h00 : rises + {4'h0, sck && !sck_q && rises != 5'h1f};
      convert_start_strobe_age <= (convert_start_strobe && !convert_start_strobe_q) ? 5'h00 : convert_start_strobe_age + {4'h0, convert_start_strobe_age != 5'h1f};
      sck_age <= (sck && !sck_q) ? 5'h00 : sck_age + {4'h0, sck_age != 5'h1f};
      quiet <= convert_start_strobe ? 5'h00 : quiet + {4'h0, quiet != 5'h1f};
    end
  end

  AST_START_DRIVES: assert property ($rose(convert_start_strobe) && quiet >= 5'h0f |-> ##[3:7] sdo_oe)
    else $error("strobe rise did not start driving");
  AST_OE_CAUSE: assert property ($rose(sdo_oe) |-> convert_start_strobe_age inside {[5'h02:5'h07]})
    else $error("drive began without a strobe rise");
  AST_DRV_ON_RISE: assert property ($changed(sdo_drv) |->
      convert_start_strobe_age inside {[5'h02:5'h07]} || sck_age inside {[5'h02:5'h07]})
    else $error("data bit changed without a clock rise");
  AST_RELEASE: assert property ($rose(sck) && rises == 5'h0f && sdo_oe |-> ##[3:7] !sdo_oe)
    else $error("data wire not released after last rise");
  AST_TRAIL_ZERO: assert property ($rose(sck) && rises == 5'(RES_BITS - 1) && sdo_oe
      |-> ##7 (!sdo_drv)[*8])
    else $error("padding bits not zero");
  AST_OE_HOLDS: assert property ($rose(sdo_oe) |-> sdo_oe[*8])
    else $error("drive dropped inside a word");
  AST_ACQ_GAP: assert property ($rose(sck) && rises == 5'h0f |->
      ##1 (!convert_start_strobe)[*8] ##1 (!convert_start_strobe)[*4])
    else $error("strobe too soon after last rise");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck[*2])
    else $error("clock high phase too short");
  AST_SCK_LOW: assert property ($fell(sck) |-> (!sck)[*2])
    else $error("clock low phase too short");
endmodule : adc_link_asserts

/* File: test/tb_serial_adc_conversion_interface.sv */
/*
  testbench: host and converter ends on one link, plus a narrow
  converter end whose pins the bench drives by hand.
  assumes the package, header and link interface are compiled first.
*/
module tb_serial_adc_conversion_interface import adc_link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RES = 14;
  localparam int HALF = 10;
  localparam logic [15:0] CP [6] = '{16'h1fff, 16'h2328, 16'h0000, 16'hec78, 16'h0000, 16'h0000};
  localparam logic [15:0] CN [6] = '{16'h0000, 16'h0000, 16'h2000, 16'h1388, 16'h0000, 16'h0001};
  logic core_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [15:0] ain_p = 16'h0000;
  logic [15:0] ain_n = 16'h0000;
  logic [15:0] bin_p = 16'h0bb8;
  logic [15:0] bin_n = 16'h0000;
  logic start_i = 1'h0;
  logic nap_i = 1'h0;
  logic sleep_i = 1'h0;
  logic wake_i = 1'h0;
  logic ready_o;
  logic data_valid_o;
  logic [RES-1:0] data_o;
  logic [2:0] dev_pwr;
  logic [2:0] host_pwr;
  logic [2:0] dev2_pwr;
  logic acq;
  logic [17:0] last = 18'h0_0000;
  int n_fail = 0;
  int checked = 0;

  adc_link_if link ();
  adc_link_if link2 ();

  // core clock, 4 ns
  always #2 core_clk_i = ~core_clk_i;

  // the two ends face each other, the narrow end faces the bench
  adc_device_end #(.RES_BITS(RES), .IN_W(16)) adc_device_end_i (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .link(link), .noninverting_analog_input_i(ain_p),
    .inverting_analog_input_i(ain_n), .power_state_o(dev_pwr), .acquiring_o(acq));
  adc_host_end #(.RES_BITS(RES), .SCK_HALF(HALF), .WAKE_CYC(20)) adc_host_end_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link(link), .start_i(start_i),
    .nap_i(nap_i), .sleep_i(sleep_i), .wake_i(wake_i), .ready_o(ready_o), .data_o(data_o),
    .data_valid_o(data_valid_o), .power_state_o(host_pwr));
  adc_device_end #(.RES_BITS(12), .IN_W(16)) adc_device_end_narrow_i (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .link(link2), .noninverting_analog_input_i(bin_p),
    .inverting_analog_input_i(bin_n), .power_state_o(dev2_pwr), .acquiring_o());
  adc_link_asserts #(.RES_BITS(RES)) adc_link_asserts_i (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .convert_start_strobe(link.convert_start_strobe), .sck(link.sck), .sdo_drv(link.sdo_drv),
    .sdo_oe(link.sdo_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [17:0] clamp(input logic [15:0] p, input logic [15:0] n,
                                        input int bits);
    logic signed [17:0] d;
    logic signed [17:0] hi;
    d = 18'($signed(p)) - 18'($signed(n));
    hi = 18'((1 << (bits - 1)) - 1);
    if (d > hi)
      d = hi;
    else if (d < -hi - 18'sh1)
      d = -hi - 18'sh1;
    return d;
  endfunction : clamp

  task automatic wait_ready();
    int k = 0;
    @(negedge core_clk_i);
    while (ready_o !== 1'h1 && k < 5000) begin
      @(negedge core_clk_i);
      k++;
    end
    check(32'(ready_o), 32'h1);
  endtask : wait_ready

  task automatic convert(input logic [15:0] p, input logic [15:0] n);
    int k = 0;
    wait_ready();
    ain_p = p;
    ain_n = n;
    start_i = 1'h1;
    @(negedge core_clk_i);
    start_i = 1'h0;
    while (data_valid_o !== 1'h1 && k < 2000) begin
      @(negedge core_clk_i);
      k++;
    end
    check(32'(data_valid_o), 32'h1);
    check(32'(data_o), 32'(last[RES-1:0]));
    check(32'(acq), 32'h1);
    last = clamp(p, n, RES);
  endtask : convert

  task automatic power(input int which, input logic [2:0] exp, input logic busy);
    wait_ready();
    nap_i = (which == 0);
    sleep_i = (which == 1);
    wake_i = (which == 2);
    @(negedge core_clk_i);
    nap_i = 1'h0;
    sleep_i = 1'h0;
    wake_i = 1'h0;
    repeat (2 * HALF + 5) @(negedge core_clk_i);
    if (busy) check(32'(ready_o), 32'h0);
    wait_ready();
    check(32'(host_pwr), 32'(exp));
    check(32'(dev_pwr), 32'(exp));
  endtask : power

  task automatic pins(input logic c, input logic s);
    link2.convert_start_strobe = c;
    link2.sck = s;
    repeat (HALF) @(negedge core_clk_i);
  endtask : pins

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    int k;
    logic [15:0] word;
    logic [17:0] code;
    link2.convert_start_strobe = 1'h0;
    link2.sck = 1'h0;
    void'($urandom(32'ha4b3_fc65));
    repeat (8) @(negedge core_clk_i);
    reset_n_i = 1'h1;
    repeat (6) @(negedge core_clk_i);
    for (int i = 0; i < 14; i++) begin
      if (i < 6) convert(CP[i], CN[i]);
      else convert(16'($urandom_range(32'h0000_5000)) - 16'h2800,
                   16'($urandom_range(32'h0000_0400)));
    end
    $display("test conversions done");
    power(0, MODE_NAP, 1'h0);
    k = 0;
    start_i = 1'h1;
    repeat (400) begin
      @(negedge core_clk_i);
      k += int'(data_valid_o === 1'h1);
    end
    start_i = 1'h0;
    check(32'(k), 32'h0);
    check(32'(dev_pwr), 32'(MODE_NAP));
    power(2, MODE_ACTIVE, 1'h0);
    convert(ain_p, ain_n);
    power(1, MODE_SLEEP, 1'h0);
    power(2, MODE_ACTIVE, 1'h1);
    convert(ain_p, ain_n);
    $display("test power modes done");
    for (int j = 0; j < 4; j++) begin
      pins(1'h1, 1'h0);
      pins(1'h0, 1'h0);
      if (j == 1) check(32'(dev2_pwr), 32'(MODE_NAP));
    end
    check(32'(dev2_pwr), 32'(MODE_SLEEP));
    pins(1'h0, 1'h1);
    pins(1'h0, 1'h0);
    check(32'(dev2_pwr), 32'(MODE_ACTIVE));
    pins(1'h1, 1'h1);
    check(32'(link2.sdo_oe), 32'h0);
    pins(1'h0, 1'h0);
    pins(1'h0, 1'h1);
    check(32'(link2.sdo_oe), 32'h1);
    repeat (16) begin
      pins(1'h0, 1'h0);
      pins(1'h0, 1'h1);
    end
    check(32'(link2.sdo_oe), 32'h0);
    pins(1'h0, 1'h0);
    pins(1'h0, 1'h0);
    pins(1'h1, 1'h0);
    word[15] = link2.sdo_line;
    for (int j = 14; j >= 0; j--) begin
      pins(1'h0, 1'h1);
      word[j] = link2.sdo_line;
      pins(1'h0, 1'h0);
    end
    pins(1'h0, 1'h1);
    check(32'(link2.sdo_oe), 32'h0);
    code = clamp(bin_p, bin_n, 12);
    check(32'(word), 32'({code[11:0], 4'h0}));
    $display("test narrow end done");
    wrap_up();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_fail++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : tb_serial_adc_conversion_interface
